// ===== hw/scfg_pkg.sv
package scfg_pkg;

  // Timing of the core clock and of the generated configuration clock
  localparam int CORE_CLK_NS       = 40;
  localparam int CFG_CLK_PERIOD_NS = 320;
  localparam int CFG_HALF_CYC      = (CFG_CLK_PERIOD_NS / 2) / CORE_CLK_NS;
  localparam int SYNC_DEPTH        = 3;
  localparam int DIV_W             = 8;

  // Mode pin encodings
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] MODE_MASTER_SPI    = 3'h1;
  localparam logic [2:0] MODE_SLAVE_SERIAL  = 3'h7;

  // Wishbone register map, byte addresses
  localparam int         ADDR_W      = 8;
  localparam int         DATA_W      = 32;
  localparam int         SEL_W       = DATA_W / 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_FWD_LEN = 8'h04;
  localparam logic [7:0] REG_OWN_LEN = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_BITCNT  = 8'h10;

  // Field positions and reset values
  localparam int          CTRL_DRIVE_DONE = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] LEN_RESET       = 32'h0000_0000;
  localparam logic [31:0] LEN_ONE         = 32'h0000_0001;
  localparam int          STATUS_PAD_W    = 16;
  localparam int          BYTE_W          = 8;
  localparam logic [2:0]  BYTE_LAST_BIT   = 3'h7;

  // CRC over the device's own bits, trailing CRC word included
  localparam int           CRC_W    = 16;
  localparam logic [15:0]  CRC_POLY = 16'h1021;
  localparam logic [15:0]  CRC_INIT = 16'hffff;
  localparam logic [15:0]  CRC_GOOD = 16'h0000;

  typedef enum logic [2:0] {
    ST_WAIT_INIT, ST_SAMPLE, ST_FWD, ST_OWN, ST_RELEASE, ST_DONE, ST_CRC_ERR, ST_UNSUP
  } scfg_state_t;

  // Pins that arrive from outside the core clock domain
  typedef struct packed {
    logic       cfg_clk;
    logic       din;
    logic       init;
    logic       done;
    logic [2:0] mode;
  } scfg_pins_t;

  localparam int PIN_W = $bits(scfg_pins_t);

  typedef struct packed {
    logic [7:0]  last_byte;
    logic [2:0]  mode;
    scfg_state_t state;
    logic        crc_err;
    logic        done_in;
  } scfg_status_t;

endpackage : scfg_pkg

// ===== hw/scfg_top.sv
// How it works
// - one configuration bit per configuration clock
// - clock pin output in master, input in slave
// - mode taken from mode pins at start
// - data taken at rising configuration clock edge
// - downstream data leaves on serial output
// - completion pin low unconfigured, high configured
// - wait while init pin held low
// - init pin driven low on CRC error
// - program pin low resets everything asynchronously
// - bytes arrive most significant bit first
// - master clock static until mode sampled
// - completion pin open drain, optional active driver
// - only first chain device enables that driver
// - startup timed by the configuration clock
// - CRC covers only this device's data
// - forwarded data first, own data last
// - release completion pin after good CRC
// - leave release phase on next rising edge with completion pin high
// - upstream master clocks, others are slaves
// - SPI mode still forwards chain data
// - master clock also times internal logic
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
module scfg_top
  import scfg_pkg::*;
#(
  parameter int HALF_CYC = CFG_HALF_CYC
) (
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RST,
  input  wire logic              I_CE,
  input  wire logic              I_PROGRAM_N,
  input  wire logic [2:0]        I_MODE,
  input  wire logic              I_CFG_CLK,
  output logic                   O_CFG_CLK,
  output logic                   O_CFG_CLK_OE,
  input  wire logic              I_DIN,
  output logic                   O_DOUT,
  input  wire logic              I_DONE,
  output logic                   O_DONE,
  output logic                   O_DONE_OE,
  input  wire logic              I_INIT,
  output logic                   O_INIT,
  output logic                   O_INIT_OE,
  input  wire logic              I_WB_CYC,
  input  wire logic              I_WB_STB,
  input  wire logic              I_WB_WE,
  input  wire logic [ADDR_W-1:0] I_WB_ADR,
  input  wire logic [DATA_W-1:0] I_WB_DAT,
  input  wire logic [SEL_W-1:0]  I_WB_SEL,
  output logic [DATA_W-1:0]      O_WB_DAT,
  output logic                   O_WB_ACK
);

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);

  scfg_state_t          state_q;
  scfg_state_t          state_d;
  scfg_pins_t           pin_raw;
  scfg_pins_t           pin_st;
  scfg_pins_t           pin_hi;
  logic [PIN_W-1:0]     pin_st_v;
  logic [PIN_W-1:0]     pin_hi_v;
  logic [DATA_W-1:0]    ctrl_q;
  logic [DATA_W-1:0]    fwd_len_q;
  logic [DATA_W-1:0]    own_len_q;
  logic [DATA_W-1:0]    bit_cnt_q;
  logic [DATA_W-1:0]    wmask;
  logic [DATA_W-1:0]    rd_data;
  logic [DIV_W-1:0]     div_cnt_q;
  logic [SYNC_DEPTH-1:0] mrise_q;
  logic [CRC_W-1:0]     crc_q;
  logic [CRC_W-1:0]     crc_next;
  logic [CRC_W-1:0]     crc_chk;
  logic [BYTE_W-1:0]    byte_sh_q;
  logic [BYTE_W-1:0]    last_byte_q;
  logic [2:0]           mode_q;
  logic                 is_master_q;
  logic                 config_clock_pin_q;
  logic                 ack_q;
  logic                 crc_err_q;

  // Pin bundle, one synchroniser per bit
  assign pin_raw  = '{cfg_clk: I_CFG_CLK, din: I_DIN, init: I_INIT, done: I_DONE, mode: I_MODE};
  assign pin_st   = scfg_pins_t'(pin_st_v);
  assign pin_hi   = scfg_pins_t'(pin_hi_v);

  // Three flops; the stable copy follows once the second and third agree
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic st_q;
      always_ff @(posedge I_CORE_CLK or negedge I_PROGRAM_N) begin
        if (!I_PROGRAM_N) begin
          {s1_q, s2_q, s3_q, st_q} <= 4'h0;
        end else if (I_RST) begin
          {s1_q, s2_q, s3_q, st_q} <= 4'h0;
        end else if (I_CE) begin
          s1_q <= pin_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            st_q <= s3_q;
          end
        end
      end
      assign pin_st_v[g] = st_q;
      assign pin_hi_v[g] = s2_q & s3_q;
    end
  endgenerate

  // Decoded phase flags
  wire running   = (state_q == ST_FWD) || (state_q == ST_OWN) || (state_q == ST_RELEASE);
  wire released  = (state_q == ST_RELEASE) || (state_q == ST_DONE);
  wire mode_ok   = (pin_st.mode == MODE_MASTER_SERIAL) || (pin_st.mode == MODE_MASTER_SPI)
                   || (pin_st.mode == MODE_SLAVE_SERIAL);
  wire mode_mst  = (pin_st.mode == MODE_MASTER_SERIAL) || (pin_st.mode == MODE_MASTER_SPI);
  wire drive_opt = ctrl_q[CTRL_DRIVE_DONE];

  // Configuration clock rising edges: generated in master, detected in slave
  wire m_rise = is_master_q && running && !config_clock_pin_q && (div_cnt_q == DIV_LAST);
  wire s_rise = !is_master_q && pin_hi.cfg_clk && !pin_st.cfg_clk;
  wire bit_ev = is_master_q ? mrise_q[SYNC_DEPTH-1] : s_rise;
  wire din    = pin_st.din;

  // Section ends, forwarded bits before own bits
  wire fwd_last = (fwd_len_q == LEN_RESET) || (bit_ev && (bit_cnt_q + LEN_ONE == fwd_len_q));
  wire own_last = (own_len_q == LEN_RESET) || (bit_ev && (bit_cnt_q + LEN_ONE == own_len_q));
  wire own_bit  = (state_q == ST_OWN) && bit_ev;
  wire fwd_bit  = (state_q == ST_FWD) && bit_ev;

  // CRC update for one own bit
  wire crc_fb = crc_q[CRC_W-1] ^ din;
  assign crc_next = {crc_q[CRC_W-2:0], 1'b0} ^ (crc_fb ? CRC_POLY : CRC_GOOD);
  assign crc_chk  = bit_ev ? crc_next : crc_q;

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAIT_INIT: begin
        if (pin_st.init) begin
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        state_d = mode_ok ? ST_FWD : ST_UNSUP;
      end
      ST_FWD: begin
        if (fwd_last) begin
          state_d = ST_OWN;
        end
      end
      ST_OWN: begin
        if (own_last) begin
          state_d = (crc_chk == CRC_GOOD) ? ST_RELEASE : ST_CRC_ERR;
        end
      end
      ST_RELEASE: begin
        if (pin_st.done && bit_ev) begin
          state_d = ST_DONE;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
  end

  // State and mode capture
  always_ff @(posedge I_CORE_CLK or negedge I_PROGRAM_N) begin
    if (!I_PROGRAM_N) begin
      state_q     <= ST_WAIT_INIT;
      mode_q      <= MODE_MASTER_SERIAL;
      is_master_q <= 1'b0;
    end else if (I_RST) begin
      state_q     <= ST_WAIT_INIT;
      mode_q      <= MODE_MASTER_SERIAL;
      is_master_q <= 1'b0;
    end else if (I_CE) begin
      state_q <= state_d;
      if (state_q == ST_SAMPLE) begin
        mode_q      <= pin_st.mode;
        is_master_q <= mode_mst;
      end
    end
  end

  // Master clock divider; idle low before mode sampling and after startup
  always_ff @(posedge I_CORE_CLK or negedge I_PROGRAM_N) begin
    if (!I_PROGRAM_N) begin
      div_cnt_q <= '0;
      config_clock_pin_q    <= 1'b0;
      mrise_q   <= '0;
    end else if (I_RST) begin
      div_cnt_q <= '0;
      config_clock_pin_q    <= 1'b0;
      mrise_q   <= '0;
    end else if (I_CE) begin
      mrise_q <= {mrise_q[SYNC_DEPTH-2:0], m_rise};                          // Align with data synchroniser
      if (is_master_q && running) begin
        div_cnt_q <= (div_cnt_q == DIV_LAST) ? '0 : div_cnt_q + 1'b1;
        if (div_cnt_q == DIV_LAST) begin
          config_clock_pin_q <= !config_clock_pin_q;
        end
      end else begin
        div_cnt_q <= '0;
        config_clock_pin_q    <= 1'b0;
      end
    end
  end

  // Bit counter, byte assembly and CRC
  always_ff @(posedge I_CORE_CLK or negedge I_PROGRAM_N) begin
    if (!I_PROGRAM_N) begin
      bit_cnt_q   <= LEN_RESET;
      crc_q       <= CRC_INIT;
      byte_sh_q   <= '0;
      last_byte_q <= '0;
    end else if (I_RST) begin
      bit_cnt_q   <= LEN_RESET;
      crc_q       <= CRC_INIT;
      byte_sh_q   <= '0;
      last_byte_q <= '0;
    end else if (I_CE) begin
      if (state_d != state_q) begin
        bit_cnt_q <= LEN_RESET;
      end else if (fwd_bit || own_bit) begin
        bit_cnt_q <= bit_cnt_q + LEN_ONE;
      end
      if (own_bit) begin
        crc_q     <= crc_next;
        byte_sh_q <= {byte_sh_q[BYTE_W-2:0], din};
        if (bit_cnt_q[2:0] == BYTE_LAST_BIT) begin
          last_byte_q <= {byte_sh_q[BYTE_W-2:0], din};
        end
      end
    end
  end

  // Pin drivers: serial out, completion and init, all registered
  always_ff @(posedge I_CORE_CLK or negedge I_PROGRAM_N) begin
    if (!I_PROGRAM_N) begin
      O_DOUT       <= 1'b0;
      O_DONE       <= 1'b0;
      O_DONE_OE    <= 1'b1;
      O_INIT       <= 1'b0;
      O_INIT_OE    <= 1'b0;
      O_CFG_CLK_OE <= 1'b0;
      crc_err_q    <= 1'b0;
    end else if (I_RST) begin
      O_DOUT       <= 1'b0;
      O_DONE       <= 1'b0;
      O_DONE_OE    <= 1'b1;
      O_INIT       <= 1'b0;
      O_INIT_OE    <= 1'b0;
      O_CFG_CLK_OE <= 1'b0;
      crc_err_q    <= 1'b0;
    end else if (I_CE) begin
      if (fwd_bit) begin
        O_DOUT <= din;
      end
      O_DONE       <= released;
      O_DONE_OE    <= !released || drive_opt;
      O_INIT       <= 1'b0;
      O_INIT_OE    <= (state_q == ST_CRC_ERR);
      O_CFG_CLK_OE <= is_master_q && (state_q != ST_WAIT_INIT) && (state_q != ST_SAMPLE);
      crc_err_q    <= (state_q == ST_CRC_ERR);
    end
  end

  assign O_CFG_CLK = config_clock_pin_q;

  // Byte lane write mask
  genvar b;
  generate
    for (b = 0; b < SEL_W; b++) begin : g_lane
      assign wmask[b*BYTE_W +: BYTE_W] = {BYTE_W{I_WB_SEL[b]}};
    end
  endgenerate

  // Bus decode and read selection; unmapped reads give zero
  wire          wb_req  = I_WB_CYC && I_WB_STB && !ack_q;
  wire          wb_wr   = wb_req && I_WB_WE;
  scfg_status_t status;
  assign status  = '{last_byte: last_byte_q, mode: mode_q, state: state_q,
                     crc_err: crc_err_q, done_in: pin_st.done};
  assign rd_data = (I_WB_ADR == REG_CTRL)    ? ctrl_q :
                   (I_WB_ADR == REG_FWD_LEN) ? fwd_len_q :
                   (I_WB_ADR == REG_OWN_LEN) ? own_len_q :
                   (I_WB_ADR == REG_STATUS)  ? {{STATUS_PAD_W{1'b0}}, status} :
                   (I_WB_ADR == REG_BITCNT)  ? bit_cnt_q : '0;

  // Register file and one-cycle acknowledge
  always_ff @(posedge I_CORE_CLK or negedge I_PROGRAM_N) begin
    if (!I_PROGRAM_N) begin
      ctrl_q    <= CTRL_RESET;
      fwd_len_q <= LEN_RESET;
      own_len_q <= LEN_RESET;
      ack_q     <= 1'b0;
      O_WB_DAT  <= '0;
    end else if (I_RST) begin
      ctrl_q    <= CTRL_RESET;
      fwd_len_q <= LEN_RESET;
      own_len_q <= LEN_RESET;
      ack_q     <= 1'b0;
      O_WB_DAT  <= '0;
    end else if (I_CE) begin
      ack_q    <= wb_req;
      O_WB_DAT <= wb_req ? rd_data : '0;
      if (wb_wr && (I_WB_ADR == REG_CTRL)) begin
        ctrl_q <= (ctrl_q & ~wmask) | (I_WB_DAT & wmask);
      end
      if (wb_wr && (I_WB_ADR == REG_FWD_LEN)) begin
        fwd_len_q <= (fwd_len_q & ~wmask) | (I_WB_DAT & wmask);
      end
      if (wb_wr && (I_WB_ADR == REG_OWN_LEN)) begin
        own_len_q <= (own_len_q & ~wmask) | (I_WB_DAT & wmask);
      end
    end
  end

  assign O_WB_ACK = ack_q;

  // Checks on the design's own behaviour
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST || !I_PROGRAM_N || !I_CE);

  sequence s_own_bit;
    (state_q == ST_OWN) && bit_ev && !own_last;
  endsequence

  sequence s_fwd_bit;
    (state_q == ST_FWD) && bit_ev;
  endsequence

  sequence s_release_go;
    (state_q == ST_RELEASE) && pin_st.done && bit_ev;
  endsequence

  one_bit_a: assert property (s_own_bit |=> bit_cnt_q == $past(bit_cnt_q) + LEN_ONE)
    else $error("own bit not counted once");
  clk_static_a: assert property ((state_q == ST_WAIT_INIT) || (state_q == ST_SAMPLE) |-> !O_CFG_CLK)
    else $error("config clock moved before mode sampling");
  clk_dir_a: assert property (running && is_master_q ##1 running |-> O_CFG_CLK_OE == 1'b1)
    else $error("master does not drive config clock");
  init_wait_a: assert property ((state_q == ST_WAIT_INIT) && !pin_st.init |=> state_q == ST_WAIT_INIT)
    else $error("left wait while init held low");
  crc_flag_a: assert property ((state_q == ST_CRC_ERR) |=> O_INIT_OE && !O_INIT)
    else $error("init pin not low after CRC error");
  done_low_a: assert property (!released ##1 !released |-> O_DONE_OE && !O_DONE)
    else $error("completion pin not held low");
  fwd_out_a: assert property (s_fwd_bit |=> O_DOUT == $past(din))
    else $error("forwarded bit not on serial output");
  release_a: assert property ((state_q == ST_RELEASE) && !drive_opt |=> !O_DONE_OE)
    else $error("completion pin not released");
  startup_a: assert property (s_release_go |=> state_q == ST_DONE)
    else $error("startup did not finish on clock edge");
  msb_first_a: assert property (s_own_bit |=> byte_sh_q[0] == $past(din))
    else $error("bit order broken");

endmodule : scfg_top

// ===== testbench/scfg_source_model.sv
module scfg_source_model (
  input  wire logic         i_run,
  input  wire logic         i_slave,
  input  wire logic         i_clk_pin,
  input  wire logic [511:0] i_frame,
  output logic              o_clk,
  output logic              o_din
);
  timeunit 1ns;
  timeprecision 1ps;

  int idx;

  // Slave clock runs only while a frame is open, off the core clock phase
  initial begin
    o_clk = 1'b0;
    o_din = 1'b0;
    forever begin
      wait (i_run && i_slave);
      #413;
      while (i_run) begin
        #160 o_clk = 1'b1;
        #160 o_clk = 1'b0;
      end
    end
  end

  // First bit is ready when the frame opens
  always @(posedge i_run) begin
    idx = 0;
    o_din = i_frame[0];
  end

  // Next bit after each falling edge, so it is settled at the rise; past the end it keeps toggling
  always @(negedge i_clk_pin) begin
    idx = idx + 1;
    o_din = (idx < 512) ? i_frame[idx] : ~o_din;
  end
endmodule : scfg_source_model

// ===== testbench/scfg_top_tb.sv
module scfg_top_tb import scfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic          clk, rst, prog_n, run, hold_init, hold_done, cyc, stb, we;
  logic [2:0]    mode;
  logic [7:0]    adr;
  logic [31:0]   wdat, rd;
  logic [3:0]    sel, wsel;
  logic [7:0]    reg_list [5];
  logic [511:0]  frame;
  logic          cfg_o, cfg_oe, src_clk, din, dout, done_o, done_oe, init_o, init_oe, ack;
  logic          q[$];
  int            err_count, checks;

  // Pin levels: clock mux, open-drain wires with pull-ups and external holders
  wire cfg_w  = cfg_oe ? cfg_o : src_clk;
  wire done_w = ~hold_done & ~(done_oe & ~done_o);
  wire init_w = ~hold_init & ~(init_oe & ~init_o);

  scfg_top dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_PROGRAM_N(prog_n), .I_MODE(mode),
    .I_CFG_CLK(cfg_w), .O_CFG_CLK(cfg_o), .O_CFG_CLK_OE(cfg_oe), .I_DIN(din), .O_DOUT(dout),
    .I_DONE(done_w), .O_DONE(done_o), .O_DONE_OE(done_oe), .I_INIT(init_w), .O_INIT(init_o),
    .O_INIT_OE(init_oe), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(rd), .O_WB_ACK(ack)
  );

  scfg_source_model src (
    .i_run(run), .i_slave(mode == MODE_SLAVE_SERIAL), .i_clk_pin(cfg_w), .i_frame(frame),
    .o_clk(src_clk), .o_din(din)
  );

  // Core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Forwarded output seen well after each configuration clock rise
  always @(posedge cfg_w) begin
    if (run) begin
      #290;
      q.push_back(dout);
    end
  end

  task automatic conclude();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= wsel;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rd;
    if (n >= 20) err_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  // Expected CRC over the device's own bits, MSB first
  function automatic logic [15:0] crc_of(input logic [511:0] f, input int s, input int n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int k = s; k < s + n; k++) c = {c[14:0], 1'b0} ^ ((c[15] ^ f[k]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_of

  // One complete load: program, hold init, stream, check outcome
  task automatic run_load(input logic [2:0] m, input logic drv, input logic bad, input logic abort);
    int          fn, on;
    logic [15:0] c;
    logic [31:0] r;
    logic        sup;
    sup = (m == MODE_MASTER_SERIAL) || (m == MODE_MASTER_SPI) || (m == MODE_SLAVE_SERIAL);
    hold_init <= 1'b1;
    hold_done <= 1'b1;
    run <= 1'b0;
    mode <= m;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    fn = 8 + $urandom % 33;
    on = 8 * (2 + $urandom % 3);
    for (int k = 0; k < 512; k++) frame[k] = 1'($urandom % 2);
    c = crc_of(frame, fn, on);
    for (int k = 0; k < 16; k++) frame[fn + on + k] = c[15 - k];
    frame[fn] = frame[fn] ^ bad;
    wb(1'b1, REG_CTRL, {31'h0, drv}, r);
    wb(1'b1, REG_FWD_LEN, 32'(fn), r);
    wb(1'b1, REG_OWN_LEN, 32'(on + 16), r);
    wb(1'b0, REG_OWN_LEN, 32'h0, r);
    chk_word(r, 32'(on + 16));
    repeat (20) @(posedge clk);
    wb(1'b0, REG_STATUS, 32'h0, r);
    chk_word(32'(r[4:2]), 32'h0);
    chk_bit(cfg_o, 1'b0);
    q.delete();
    hold_init <= 1'b0;
    run <= 1'b1;
    repeat (60) @(posedge clk);
    chk_bit(cfg_oe, sup && m != MODE_SLAVE_SERIAL);
    chk_bit(done_oe & ~done_o, 1'b1);
    wb(1'b0, REG_STATUS, 32'h0, r);
    chk_word(32'(r[7:5]), 32'(m));
    if (abort) begin
      prog_n <= 1'b0;
      #5;
      chk_word(32'({done_oe, done_o, cfg_oe, dout, init_oe}), 32'h10);
      @(posedge clk);
      prog_n <= 1'b1;
      wb(1'b0, REG_FWD_LEN, 32'h0, r);
      chk_word(r, 32'h0);
    end else if (!sup) begin
      chk_word(32'({r[4:2], init_oe, done_oe & ~done_o}), 32'h1d);
    end else begin
      for (int n = 0; n < 3000 && done_oe && !done_o && !init_oe; n++) @(posedge clk);
      wb(1'b0, REG_STATUS, 32'h0, r);
      if (bad) begin
        chk_bit(init_w, 1'b0);
        chk_word(32'({r[4:1], done_oe & ~done_o}), 32'h1b);
      end else begin
        chk_bit(init_w, 1'b1);
        chk_word(32'({done_oe, done_oe & done_o}), drv ? 32'h3 : 32'h0);
        chk_word(32'(r[4:1]), 32'h8);
        hold_done <= 1'b0;
        repeat (60) @(posedge clk);
        wb(1'b0, REG_STATUS, 32'h0, r);
        chk_word(32'(r[7:0]), 32'({m, 3'h5, 2'b01}));
        chk_word(32'(r[15:8]), 32'(c[7:0]));
        chk_bit(q.size() >= fn, 1'b1);
        for (int k = 0; k < fn && k < q.size(); k++) chk_bit(q[k], frame[k]);
      end
    end
    run <= 1'b0;
    $display("test mode=%h drive=%0d bad=%0d abort=%0d done", m, drv, bad, abort);
  endtask : run_load

  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [31:0] r, v, v2;
    rst = 1'b1;
    prog_n = 1'b1;
    run = 1'b0;
    hold_init = 1'b1;
    hold_done = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hf;
    wsel = 4'hf;
    reg_list = '{REG_CTRL, REG_FWD_LEN, REG_OWN_LEN, REG_BITCNT, 8'h14};
    mode = MODE_SLAVE_SERIAL;
    frame = '0;
    err_count = 0;
    checks = 0;
    void'($urandom(32'h335b69a6));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (reg_list[i]) begin
      wb(1'b0, reg_list[i], 32'h0, r);
      chk_word(r, 32'h0);
    end
    v = $urandom;
    wb(1'b1, REG_FWD_LEN, v, r);
    wb(1'b1, 8'h14, v, r);
    wb(1'b1, REG_BITCNT, v, r);
    wb(1'b0, REG_FWD_LEN, 32'h0, r);
    chk_word(r, v);
    // Byte lanes 0 and 2 only: the other lanes keep their old value
    v2 = $urandom;
    wsel = 4'h5;
    wb(1'b1, REG_FWD_LEN, v2, r);
    wsel = 4'hf;
    wb(1'b0, REG_FWD_LEN, 32'h0, r);
    chk_word(r, (v & 32'hff00ff00) | (v2 & 32'h00ff00ff));
    wb(1'b0, 8'h14, 32'h0, r);
    chk_word(r, 32'h0);
    wb(1'b0, REG_BITCNT, 32'h0, r);
    chk_word(r, 32'h0);
    $display("test registers done");
    run_load(MODE_MASTER_SERIAL, 1'b1, 1'b0, 1'b0);
    run_load(MODE_MASTER_SPI, 1'($urandom % 2), 1'b0, 1'b0);
    run_load(MODE_SLAVE_SERIAL, 1'b0, 1'b0, 1'b0);
    run_load(MODE_SLAVE_SERIAL, 1'b0, 1'b1, 1'b0);
    run_load(MODE_MASTER_SERIAL, 1'b0, 1'b1, 1'b0);
    run_load(MODE_SLAVE_SERIAL, 1'b0, 1'b0, 1'b1);
    run_load(3'h3, 1'b0, 1'b0, 1'b0);
    conclude();
  end
endmodule : scfg_top_tb
